// ---- verilog/xcap_cfg.svh ----
`ifndef XCAP_CFG_SVH
`define XCAP_CFG_SVH
// Clock rate in kHz (25 MHz)
`define XCAP_CLK_KHZ        25000
// Hold-off after last mains peak, ms
`define XCAP_HOLDOFF_MS     120
// Re-arm delay after completed discharge, ms
`define XCAP_REARM_MS       118
// Off-time between pulses, us (min / max of allowed window)
`define XCAP_OFF_MIN_US     1880
`define XCAP_OFF_MAX_US     6400
// Chosen off-time inside the window, us
`define XCAP_OFF_US         4000
`define XCAP_HOLDOFF_CYC    (`XCAP_HOLDOFF_MS * `XCAP_CLK_KHZ)
`define XCAP_REARM_CYC      (`XCAP_REARM_MS * `XCAP_CLK_KHZ)
`define XCAP_OFF_CYC        ((`XCAP_OFF_US * `XCAP_CLK_KHZ) / 1000)
`define XCAP_OFF_MIN_CYC    ((`XCAP_OFF_MIN_US * `XCAP_CLK_KHZ + 999) / 1000)
`define XCAP_OFF_MAX_CYC    ((`XCAP_OFF_MAX_US * `XCAP_CLK_KHZ) / 1000)
`define XCAP_CNT_W          32
`endif

// ---- verilog/xcap_pkg.sv ----
package xcap_pkg;
  // Synchronised comparator bundle
  typedef struct packed {
    logic mainsRise;
    logic curAbove10m;
    logic curAbove50m;
    logic gateAbove10v;
  } sense_t;

  // Gate current source controls
  typedef struct packed {
    logic chargeOn;
    logic sinkOn;
    logic highZ;
  } gate_t;

  typedef enum logic [2:0] {
    ST_WATCH, ST_CHARGE, ST_SINK, ST_OFF, ST_REARM
  } state_t;
endpackage : xcap_pkg

// ---- verilog/xcap_sync.sv ----
`timescale 1ns/1ps
module xcap_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end
endmodule : xcap_sync

// ---- verilog/xcap_discharge_sequencer.sv ----
`timescale 1ns/1ps
`include "xcap_cfg.svh"
module xcap_discharge_sequencer #(
  parameter int HOLDOFF_CYC = `XCAP_HOLDOFF_CYC,
  parameter int REARM_CYC   = `XCAP_REARM_CYC,
  parameter int OFF_CYC     = `XCAP_OFF_CYC
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Comparator pins
  input  wire logic mainsRiseIn,
  input  wire logic curAbove10mIn,
  input  wire logic curAbove50mIn,
  input  wire logic gateAbove10vIn,
  // System run level
  input  wire logic systemRun,
  // Gate drive controls
  output logic      gateCharge,
  output logic      gateSink,
  output logic      gateHighZ,
  // Status
  output logic      discharging,
  output logic      dischargeDone,
  output logic      dischargeAbort
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  xcap_pkg::sense_t sense;
  logic [4:0]       syncOut;
  logic             run;

  xcap_sync #(
    .W (5)
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   ({mainsRiseIn, curAbove10mIn, curAbove50mIn, gateAbove10vIn, systemRun}),
    .dout  (syncOut)
  );

  assign sense = xcap_pkg::sense_t'(syncOut[4:1]);
  assign run   = syncOut[0];

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  localparam int CW = `XCAP_CNT_W;

  xcap_pkg::state_t state;
  xcap_pkg::state_t next_state;
  logic [CW-1:0]    cnt;
  logic [CW-1:0]    next_cnt;
  xcap_pkg::gate_t  gate;
  xcap_pkg::gate_t  next_gate;
  logic             next_done;
  logic             next_abort;
  logic             mainsPrev;
  logic             mainsEdge;

  // A level held high by the comparator is one rise, not many
  assign mainsEdge = sense.mainsRise & ~mainsPrev;

  // Any of these ends a pulse phase; only overcurrent reports an abort
  function automatic logic pulse_stop(input logic over50m,
                                      input logic riseSeen,
                                      input logic runLevel);
    return over50m || riseSeen || !runLevel;
  endfunction : pulse_stop

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_done  = 1'b0;
    next_abort = 1'b0;
    unique case (state)
      xcap_pkg::ST_WATCH: begin
        // Hold-off runs from the peak: held at zero while mains still rises
        if (sense.mainsRise || !run || sense.curAbove10m) begin
          next_cnt = '0;
        end else if (cnt >= CW'(HOLDOFF_CYC - 1)) begin
          next_state = xcap_pkg::ST_CHARGE;
          next_cnt   = '0;
        end else begin
          next_cnt = cnt + CW'(1);
        end
      end
      xcap_pkg::ST_CHARGE: begin
        if (pulse_stop(sense.curAbove50m, mainsEdge, run)) begin
          next_state = xcap_pkg::ST_WATCH;
          next_cnt   = '0;
          next_abort = sense.curAbove50m;
        end else if (sense.gateAbove10v && !sense.curAbove10m) begin
          next_state = xcap_pkg::ST_REARM;
          next_cnt   = '0;
          next_done  = 1'b1;
        end else if (sense.curAbove10m) begin
          next_state = xcap_pkg::ST_SINK;
        end
      end
      xcap_pkg::ST_SINK: begin
        if (pulse_stop(sense.curAbove50m, mainsEdge, run)) begin
          next_state = xcap_pkg::ST_WATCH;
          next_cnt   = '0;
          next_abort = sense.curAbove50m;
        end else if (!sense.curAbove10m) begin
          // Gate keeps sinking through the off-time; pulse ends here
          next_state = xcap_pkg::ST_OFF;
          next_cnt   = '0;
        end
      end
      xcap_pkg::ST_OFF: begin
        if (pulse_stop(sense.curAbove50m, mainsEdge, run)) begin
          next_state = xcap_pkg::ST_WATCH;
          next_cnt   = '0;
          next_abort = sense.curAbove50m;
        end else if (cnt >= CW'(OFF_CYC - 1)) begin
          next_state = xcap_pkg::ST_CHARGE;
          next_cnt   = '0;
        end else begin
          next_cnt = cnt + CW'(1);
        end
      end
      xcap_pkg::ST_REARM: begin
        if (mainsEdge || !run) begin
          next_state = xcap_pkg::ST_WATCH;
          next_cnt   = '0;
        end else if (cnt >= CW'(REARM_CYC - 1)) begin
          next_state = xcap_pkg::ST_CHARGE;
          next_cnt   = '0;
        end else begin
          next_cnt = cnt + CW'(1);
        end
      end
    endcase
  end

  // Gate controls follow the next state, so outputs stay registered
  always_comb begin
    next_gate = '0;
    unique case (next_state)
      xcap_pkg::ST_CHARGE: begin
        next_gate.chargeOn = 1'b1;
        next_gate.highZ    = 1'b1;
      end
      xcap_pkg::ST_SINK, xcap_pkg::ST_OFF: begin
        next_gate.sinkOn = 1'b1;
        next_gate.highZ  = 1'b1;
      end
      default: begin
        next_gate = '0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state          <= xcap_pkg::ST_WATCH;
      cnt            <= '0;
      gate           <= '0;
      mainsPrev      <= 1'b0;
      dischargeDone  <= 1'b0;
      dischargeAbort <= 1'b0;
    end else begin
      state          <= next_state;
      cnt            <= next_cnt;
      gate           <= next_gate;
      mainsPrev      <= sense.mainsRise;
      dischargeDone  <= next_done;
      dischargeAbort <= next_abort;
    end
  end

  assign gateCharge  = gate.chargeOn;
  assign gateSink    = gate.sinkOn;
  assign gateHighZ   = gate.highZ;
  assign discharging = gate.highZ;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  localparam int     OFF_MIN   = `XCAP_OFF_MIN_CYC;
  localparam int     OFF_MAX   = `XCAP_OFF_MAX_CYC;
  localparam longint FULL_HOLD = `XCAP_HOLDOFF_CYC;

  // Window scaled by the hold-off, so shortened timing keeps its proportions
  initial begin
    a_off_window: assert (
      longint'(OFF_CYC) * FULL_HOLD >= longint'(OFF_MIN) * HOLDOFF_CYC &&
      longint'(OFF_CYC) * FULL_HOLD <= longint'(OFF_MAX) * HOLDOFF_CYC)
      else $error("off-time outside allowed window");
  end

  a_no_both_sources: assert property (@(posedge mclk) disable iff (!rst_n)
    !(gateCharge && gateSink))
    else $error("charge and sink sources on together");

  a_abort_driver_off: assert property (@(posedge mclk) disable iff (!rst_n)
    (state != xcap_pkg::ST_WATCH && state != xcap_pkg::ST_REARM && sense.curAbove50m)
      |=> (!gateHighZ && dischargeAbort))
    else $error("overcurrent did not end discharge");

  a_start_charge: assert property (@(posedge mclk) disable iff (!rst_n)
    (state != xcap_pkg::ST_CHARGE && next_state == xcap_pkg::ST_CHARGE)
      |=> (gateCharge && gateHighZ))
    else $error("pulse did not start with charging");

  a_sink_on_10m: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == xcap_pkg::ST_CHARGE && sense.curAbove10m && !sense.curAbove50m
      && !mainsEdge && run) |=> (gateSink && !gateCharge))
    else $error("no switch to sink at current threshold");

  a_done_end: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == xcap_pkg::ST_CHARGE && sense.gateAbove10v && !sense.curAbove10m
      && !sense.curAbove50m && !mainsEdge && run) |=> (dischargeDone && !gateHighZ))
    else $error("full discharge not recognised");

  a_off_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == xcap_pkg::ST_OFF && cnt < CW'(OFF_CYC - 1)) |=> !gateCharge)
    else $error("pulse repeated before off-time");

  a_offset_disable: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == xcap_pkg::ST_WATCH && sense.curAbove10m) |=> (state == xcap_pkg::ST_WATCH))
    else $error("discharge started with current offset");

  a_rise_resets: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == xcap_pkg::ST_WATCH && mainsEdge) |=> (cnt == '0 && !discharging))
    else $error("mains rise did not restart hold-off");

  a_rearm_reconnect: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == xcap_pkg::ST_REARM && mainsEdge) |=> (state == xcap_pkg::ST_WATCH))
    else $error("reconnection did not cancel re-arm");

  // ---------------------------------------------------------------
  // Phase and status checks
  // ---------------------------------------------------------------
  a_watch_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == xcap_pkg::ST_WATCH && next_state == xcap_pkg::ST_WATCH)
      |=> (!discharging && !gateCharge && !gateSink))
    else $error("driver released while watching mains");

  a_holdoff_held: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == xcap_pkg::ST_WATCH && sense.mainsRise)
      |=> (cnt == '0 && state == xcap_pkg::ST_WATCH))
    else $error("hold-off counted while mains still rising");

  a_holdoff_start: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == xcap_pkg::ST_WATCH && run && !sense.mainsRise && !sense.curAbove10m
      && cnt == CW'(HOLDOFF_CYC - 1)) |=> (gateCharge && gateHighZ))
    else $error("discharge not started after hold-off");

  a_off_sinks: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == xcap_pkg::ST_OFF) |-> (gateSink && !gateCharge && gateHighZ))
    else $error("gate not held low between pulses");

  a_off_restart: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == xcap_pkg::ST_OFF && cnt == CW'(OFF_CYC - 1) && run && !mainsEdge
      && !sense.curAbove50m) |=> (gateCharge && !gateSink))
    else $error("pulse not repeated after off-time");

  a_done_state: assert property (@(posedge mclk) disable iff (!rst_n)
    dischargeDone |-> (state == xcap_pkg::ST_REARM && !gateHighZ))
    else $error("completion flagged outside re-arm wait");

  a_rearm_driver: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == xcap_pkg::ST_REARM) |-> (!gateHighZ && !gateCharge && !gateSink))
    else $error("driver released during re-arm wait");

  a_rearm_restart: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == xcap_pkg::ST_REARM && cnt == CW'(REARM_CYC - 1) && run && !mainsEdge)
      |=> (gateCharge && gateHighZ))
    else $error("discharge not reactivated after re-arm delay");

  a_stop_ends: assert property (@(posedge mclk) disable iff (!rst_n)
    (state != xcap_pkg::ST_WATCH && !run) |=> (state == xcap_pkg::ST_WATCH && !gateHighZ))
    else $error("stopped system left discharge running");

  a_reconnect_ends: assert property (@(posedge mclk) disable iff (!rst_n)
    (state != xcap_pkg::ST_WATCH && mainsEdge)
      |=> (state == xcap_pkg::ST_WATCH && !gateHighZ))
    else $error("mains reconnection did not end discharge");

  a_abort_state: assert property (@(posedge mclk) disable iff (!rst_n)
    dischargeAbort |-> (state == xcap_pkg::ST_WATCH && !gateHighZ && !gateCharge))
    else $error("abort flagged with driver still released");

  a_offset_blocks: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == xcap_pkg::ST_WATCH && sense.curAbove10m) |=> (cnt == '0 && !gateHighZ))
    else $error("hold-off counted with current offset");

  a_sync_latency: assert property (@(posedge mclk) disable iff (!rst_n)
    sense.mainsRise == $past(mainsRiseIn, 2))
    else $error("mains comparator not seen two edges later");
endmodule : xcap_discharge_sequencer

// ---- verif/xcap_fet_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// External switch and sense network
// ----------------------------------------
module xcap_fet_model (
  // Clock
  input  wire logic mclk,
  // Gate controls from the sequencer
  input  wire logic gateCharge,
  input  wire logic gateSink,
  input  wire logic gateHighZ,
  // Scenario controls
  input  wire logic capEmpty,
  input  wire logic mainsBack,
  input  wire logic offset,
  // Comparator outputs
  output logic      curAbove10mIn,
  output logic      curAbove50mIn,
  output logic      gateAbove10vIn
);
  logic [5:0] vg;
  initial vg = 6'h00;
  // Gate voltage moves slowly; the normal driver clamps it low
  always @(posedge mclk) begin
    if (!gateHighZ) vg <= 6'h00;
    else if (gateCharge && vg != 6'h3F) vg <= vg + 6'h01;
    else if (gateSink && vg != 6'h00) vg <= vg - 6'h01;
  end
  assign curAbove10mIn  = offset || (!capEmpty && vg >= 6'h08);
  // Reconnected mains makes the current run away
  assign curAbove50mIn  = mainsBack && vg >= 6'h08;
  assign gateAbove10vIn = vg >= 6'h1E;
endmodule : xcap_fet_model

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Sequencer bench
// ----------------------------------------
module tb_top;
  // One cycle per millisecond keeps the off-time window in proportion
  localparam int HOLD = 120;
  localparam int REARM = 118;
  localparam int OFF = 4;
  logic mclk, rst_n, mainsRiseIn, systemRun, capEmpty, mainsBack, offset;
  logic curAbove10mIn, curAbove50mIn, gateAbove10vIn;
  logic gateCharge, gateSink, gateHighZ, discharging, dischargeDone, dischargeAbort;
  logic [1:0]  notes[$];
  logic [31:0] lfsrState;
  int          mismatches, cmp_count, cycles, n;

  xcap_discharge_sequencer #(.HOLDOFF_CYC(HOLD), .REARM_CYC(REARM), .OFF_CYC(OFF)) dut (
    .mclk(mclk), .rst_n(rst_n), .mainsRiseIn(mainsRiseIn), .curAbove10mIn(curAbove10mIn),
    .curAbove50mIn(curAbove50mIn), .gateAbove10vIn(gateAbove10vIn), .systemRun(systemRun),
    .gateCharge(gateCharge), .gateSink(gateSink), .gateHighZ(gateHighZ),
    .discharging(discharging), .dischargeDone(dischargeDone), .dischargeAbort(dischargeAbort));
  xcap_fet_model fet (
    .mclk(mclk), .gateCharge(gateCharge), .gateSink(gateSink), .gateHighZ(gateHighZ),
    .capEmpty(capEmpty), .mainsBack(mainsBack), .offset(offset),
    .curAbove10mIn(curAbove10mIn), .curAbove50mIn(curAbove50mIn),
    .gateAbove10vIn(gateAbove10vIn));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) begin
      @(posedge mclk);
      #1;
    end
  endtask : tick

  // Bounded wait: 0 charge, 1 sink, 2 driver released
  task automatic wait_level(input int sel, input logic lvl, input int maxn, output int cnt);
    cnt = 0;
    while ((sel == 0 ? gateCharge : sel == 1 ? gateSink : gateHighZ) !== lvl && cnt < maxn) begin
      tick(1);
      cnt++;
    end
  endtask : wait_level

  task automatic mains_pulse(input int w);
    @(posedge mclk);
    mainsRiseIn <= 1'b1;
    repeat (w) @(posedge mclk);
    mainsRiseIn <= 1'b0;
  endtask : mains_pulse

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Done and abort pulses are matched against the oldest note
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      tally_and_finish();
    end
    if (rst_n && (dischargeDone || dischargeAbort)) begin
      if (notes.size() == 0) check("event", {dischargeDone, dischargeAbort}, 2'b00);
      else check("event", {dischargeDone, dischargeAbort}, notes.pop_front());
    end
  end

  initial begin
    {rst_n, mainsRiseIn, capEmpty, mainsBack, offset} = 5'h00;
    systemRun = 1'b1;
    lfsrState = 32'h7991FA7E;
    tick(4);
    check("reset", {gateCharge, gateSink, gateHighZ, discharging}, 4'h0);
    @(posedge mclk);
    rst_n <= 1'b1;
    // Mains present: rises closer than the hold-off never start discharge
    repeat (4) begin
      lfsrState = lfsr(lfsrState);
      mains_pulse(1 + int'(lfsrState[4:3]));
      tick(HOLD / 2 + int'(lfsrState[2:0]));
      check("watch", gateHighZ, 1'b0);
    end
    mains_pulse(1);
    wait_level(0, 1'b1, HOLD + 20, n);
    check("holdoff", n >= HOLD - 4 && n <= HOLD + 8, 1'b1);
    check("released", {gateHighZ, discharging}, 2'h3);
    $display("test holdoff finished");
    repeat (2) begin
      wait_level(1, 1'b1, 40, n);
      check("charge to sink", {gateCharge, gateSink}, 2'h1);
      wait_level(0, 1'b1, OFF + 40, n);
      check("off time", n >= OFF && n <= OFF + 14, 1'b1);
      check("sink off", gateSink, 1'b0);
    end
    $display("test pulses finished");
    capEmpty <= 1'b1;
    notes.push_back(2'h2);
    wait_level(2, 1'b0, 60, n);
    check("done", n < 60, 1'b1);
    capEmpty <= 1'b0;
    wait_level(0, 1'b1, REARM + 20, n);
    check("rearm", n >= REARM && n <= REARM + 8, 1'b1);
    $display("test rearm finished");
    mainsBack <= 1'b1;
    notes.push_back(2'h1);
    wait_level(2, 1'b0, 40, n);
    check("abort", {gateCharge, gateSink, n < 40}, 3'h1);
    mainsBack <= 1'b0;
    $display("test abort finished");
    wait_level(0, 1'b1, HOLD + 20, n);
    mains_pulse(1);
    wait_level(2, 1'b0, 20, n);
    check("reconnect", n < 20, 1'b1);
    $display("test reconnect finished");
    wait_level(0, 1'b1, HOLD + 20, n);
    capEmpty <= 1'b1;
    notes.push_back(2'h2);
    wait_level(2, 1'b0, 60, n);
    @(posedge mclk);
    systemRun <= 1'b0;
    capEmpty <= 1'b0;
    tick(REARM + 10);
    check("stopped", gateHighZ, 1'b0);
    @(posedge mclk);
    systemRun <= 1'b1;
    offset <= 1'b1;
    tick(3 * HOLD);
    check("offset", gateHighZ, 1'b0);
    offset <= 1'b0;
    wait_level(0, 1'b1, HOLD + 20, n);
    check("restart", n < HOLD + 20, 1'b1);
    $display("test disable finished");
    tick(5);
    check("notes left", notes.size(), 0);
    tally_and_finish();
  end
endmodule : tb_top
